// ### src/vim_top.sv
`timescale 1ns/1ps
module vim_top #(
  parameter int unsigned NUM_CHANNELS = vim_pkg::NUM_CHANNELS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NUM_CHANNELS-1:0] chan_req,
  input wire logic [NUM_CHANNELS-1:0] chan_enable,
  input wire logic prio_we,
  input wire logic [6:0] prio_sel,
  input wire logic [3:0] prio_wdata,
  input wire logic clock_security_fail,
  input wire logic supply_voltage_detector,
  input wire logic [6:0] first_dma_channel_irq,
  input wire logic [1:0] converter_irq,
  input wire vim_pkg::vim_core_exc_t core_exc,
  input wire logic pend_set,
  input wire logic pend_clear,
  input wire logic reset_req,
  input wire logic exc_taken,
  output vim_pkg::vim_req_t core_req,
  output logic pend_state,
  output logic [23:0] tick_calib
);
  // ---------------------------------------------------------------------------
  // Synchronisers for asynchronous event pins
  // ---------------------------------------------------------------------------
  // Core faults, pend strobes and reset_req come from core_clk logic and skip this
  localparam int unsigned SYNC_W = NUM_CHANNELS + 11;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {chan_req, clock_security_fail, supply_voltage_detector,
                first_dma_channel_irq, converter_irq};
      sync2 <= sync1;
    end
  end
  logic [NUM_CHANNELS-1:0] chan_s;
  logic csm_s;
  logic svd_s;
  logic [6:0] dma_s;
  logic [1:0] adc_s;
  assign {chan_s, csm_s, svd_s, dma_s, adc_s} = sync2;

  // ---------------------------------------------------------------------------
  // Dedicated source mapping
  // ---------------------------------------------------------------------------
  // Supply, DMA and converter sources are ORed onto their fixed channel positions; the clock failure pin goes to the NMI
  logic [NUM_CHANNELS-1:0] chan_pend;
  always_comb begin
    chan_pend = chan_s;
    chan_pend[vim_pkg::SUPPLY_CHANNEL] = chan_s[vim_pkg::SUPPLY_CHANNEL] | svd_s;
    for (int i = 0; i < 7; i++) begin
      chan_pend[vim_pkg::DMA_FIRST_CHANNEL + i] =
        chan_s[vim_pkg::DMA_FIRST_CHANNEL + i] | dma_s[i];
    end
    chan_pend[vim_pkg::CONVERTER_CHANNEL] =
      chan_s[vim_pkg::CONVERTER_CHANNEL] | (|adc_s);
  end

  // ---------------------------------------------------------------------------
  // Priority storage
  // ---------------------------------------------------------------------------
  // Index 0..67 are channels, 68..71 the settable core exceptions
  localparam int unsigned NUM_PRIO = NUM_CHANNELS + 4;
  logic [vim_pkg::PRIO_BITS-1:0] prio [NUM_PRIO];
  logic signed [5:0] slot_rank [NUM_PRIO];
  genvar g;
  generate
    for (g = 0; g < NUM_PRIO; g++) begin : g_prio
      logic [3:0] rst_val;
      if (g == NUM_CHANNELS) begin : g_a
        assign rst_val = vim_pkg::PRIO_ACCESS_RST;
      end else if (g == NUM_CHANNELS + 1) begin : g_i
        assign rst_val = vim_pkg::PRIO_INSTR_RST;
      end else if (g == NUM_CHANNELS + 2) begin : g_s
        assign rst_val = vim_pkg::PRIO_SVC_RST;
      end else if (g == NUM_CHANNELS + 3) begin : g_p
        assign rst_val = vim_pkg::PRIO_PEND_RST;
      end else begin : g_c
        // Only 4 bits exist, so defaults past 15 saturate at the lowest level
        localparam int unsigned DP = g + vim_pkg::CHAN_PRIO_OFFSET;
        assign rst_val = (DP > 15) ? 4'hf : 4'(DP);
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          prio[g] <= rst_val;
        end else if (prio_we && prio_sel == 7'(g)) begin
          prio[g] <= prio_wdata;
        end
      end
      // Zero-extended so settable levels always rank below the fixed negative ones
      assign slot_rank[g] = $signed({2'b00, prio[g]});
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Pendable service request flag
  // ---------------------------------------------------------------------------
  logic pend_taken;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_state <= 1'b0;
    end else if (pend_set) begin
      pend_state <= 1'b1;
    end else if (pend_clear || pend_taken) begin
      pend_state <= 1'b0;
    end
  end
  assign pend_taken = exc_taken && core_req.number == vim_pkg::EXC_PEND;

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  vim_pkg::vim_req_t next_req;
  always_comb begin
    next_req.valid = 1'b0;
    next_req.number = vim_pkg::EXC_NONE;
    next_req.rank = vim_pkg::RANK_IDLE;
    next_req.vector = 32'h0000_0000;
    // Scan from highest position down so less-or-equal leaves the lowest index
    for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
      if (chan_pend[i] && chan_enable[i] && slot_rank[i] <= next_req.rank) begin
        next_req.valid = 1'b1;
        next_req.number = 7'(i + vim_pkg::NUM_CORE_LINES);
        next_req.rank = slot_rank[i];
        next_req.vector = vim_pkg::VEC_CHAN_BASE + 32'(i * 4);
      end
    end
    // Core exceptions are tested after the channels, so they win equal ranks
    if (pend_state && slot_rank[NUM_CHANNELS+3] <= next_req.rank) begin
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_PEND;
      next_req.rank = slot_rank[NUM_CHANNELS+3];
      next_req.vector = vim_pkg::VEC_PEND;
    end
    if (core_exc.svc && slot_rank[NUM_CHANNELS+2] <= next_req.rank) begin
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_SVC;
      next_req.rank = slot_rank[NUM_CHANNELS+2];
      next_req.vector = vim_pkg::VEC_SVC;
    end
    if (core_exc.instr_fault && slot_rank[NUM_CHANNELS+1] <= next_req.rank) begin
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_INSTR;
      next_req.rank = slot_rank[NUM_CHANNELS+1];
      next_req.vector = vim_pkg::VEC_INSTR;
    end
    if (core_exc.access_fault && slot_rank[NUM_CHANNELS] <= next_req.rank) begin
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_ACCESS;
      next_req.rank = slot_rank[NUM_CHANNELS];
      next_req.vector = vim_pkg::VEC_ACCESS;
    end
    // Fixed ranks sit above every settable level, so no comparison is needed
    if (core_exc.severe) begin
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_SEVERE;
      next_req.rank = vim_pkg::RANK_SEVERE;
      next_req.vector = vim_pkg::VEC_SEVERE;
    end
    if (csm_s) begin
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_NMI;
      next_req.rank = vim_pkg::RANK_NMI;
      next_req.vector = vim_pkg::VEC_NMI;
    end
    if (reset_req) begin
      // The core does the reset fetch itself; the entry is reported for ranking
      next_req.valid = 1'b1;
      next_req.number = vim_pkg::EXC_RESET;
      next_req.rank = vim_pkg::RANK_RESET;
      next_req.vector = vim_pkg::VEC_RESET;
    end
  end

  // ---------------------------------------------------------------------------
  // Output register
  // ---------------------------------------------------------------------------
  // Re-evaluated every cycle, so a late better request replaces one being entered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_req <= '{valid: 1'b0, number: vim_pkg::EXC_NONE, rank: vim_pkg::RANK_IDLE,
                    vector: 32'h0000_0000};
    end else begin
      core_req <= next_req;
    end
  end

  // ---------------------------------------------------------------------------
  // Tick calibration
  // ---------------------------------------------------------------------------
  // Held in a register so the output comes straight from a flip-flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_calib <= vim_pkg::TICK_CALIB;
    end else begin
      tick_calib <= vim_pkg::TICK_CALIB;
    end
  end
endmodule // vim_top

// ### src/vim_pkg.sv
package vim_pkg;
  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS = 68;
  localparam int unsigned NUM_CORE_LINES = 16;
  localparam int unsigned PRIO_BITS = 4;
  localparam int unsigned NUM_PRIO_LEVELS = 16;
  // ---------------------------------------------------------------------------
  // System tick calibration
  // ---------------------------------------------------------------------------
  localparam int unsigned TICK_CLK_HZ = 9000000;
  localparam int unsigned TICK_REF_US = 1000;
  localparam logic [23:0] TICK_CALIB = 24'(TICK_CLK_HZ / 1000000 * TICK_REF_US);
  // ---------------------------------------------------------------------------
  // Exception numbers, vectors and default priorities
  // ---------------------------------------------------------------------------
  localparam logic [6:0] EXC_RESET = 7'h01;
  localparam logic [6:0] EXC_NMI = 7'h02;
  localparam logic [6:0] EXC_SEVERE = 7'h03;
  localparam logic [6:0] EXC_ACCESS = 7'h05;
  localparam logic [6:0] EXC_INSTR = 7'h06;
  localparam logic [6:0] EXC_SVC = 7'h0b;
  localparam logic [6:0] EXC_PEND = 7'h0e;
  localparam logic [6:0] EXC_NONE = 7'h00;
  localparam logic [31:0] VEC_RESET = 32'h0000_0004;
  localparam logic [31:0] VEC_NMI = 32'h0000_0008;
  localparam logic [31:0] VEC_SEVERE = 32'h0000_000c;
  localparam logic [31:0] VEC_ACCESS = 32'h0000_0014;
  localparam logic [31:0] VEC_INSTR = 32'h0000_0018;
  localparam logic [31:0] VEC_SVC = 32'h0000_002c;
  localparam logic [31:0] VEC_PEND = 32'h0000_0038;
  localparam logic [31:0] VEC_CHAN_BASE = 32'h0000_0040;
  localparam logic [3:0] PRIO_ACCESS_RST = 4'h1;
  localparam logic [3:0] PRIO_INSTR_RST = 4'h2;
  localparam logic [3:0] PRIO_SVC_RST = 4'h3;
  localparam logic [3:0] PRIO_PEND_RST = 4'h5;
  localparam int unsigned CHAN_PRIO_OFFSET = 7;
  localparam int unsigned SUPPLY_CHANNEL = 1;
  localparam int unsigned DMA_FIRST_CHANNEL = 11;
  localparam int unsigned CONVERTER_CHANNEL = 18;
  // Signed rank: fixed levels -3..-1, settable 0..15, idle 16
  localparam logic signed [5:0] RANK_RESET = -6'sd3;
  localparam logic signed [5:0] RANK_NMI = -6'sd2;
  localparam logic signed [5:0] RANK_SEVERE = -6'sd1;
  localparam logic signed [5:0] RANK_IDLE = 6'sd16;

  typedef struct packed {
    logic valid;
    logic [6:0] number;
    logic signed [5:0] rank;
    logic [31:0] vector;
  } vim_req_t;

  typedef struct packed {
    logic access_fault;
    logic instr_fault;
    logic svc;
    logic severe;
  } vim_core_exc_t;
endpackage

// ### dv/vim_checker.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------------------
module vim_checker #(
  parameter int unsigned NUM_CHANNELS = vim_pkg::NUM_CHANNELS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clock_security_fail,
  input wire logic reset_req,
  input wire vim_pkg::vim_core_exc_t core_exc,
  input wire logic pend_set,
  input wire logic pend_clear,
  input wire logic exc_taken,
  input wire vim_pkg::vim_req_t core_req,
  input wire logic pend_state,
  input wire logic [23:0] tick_calib
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_calib;
    tick_calib == 24'h002328;
  endproperty
  a_calib: assert property (p_calib) else $error("calibration constant wrong");
  property p_reset;
    reset_req |=> core_req.valid && core_req.rank == vim_pkg::RANK_RESET
      && core_req.vector == 32'h0000_0004;
  endproperty
  a_reset: assert property (p_reset) else $error("reset request not on top");
  // Three samples cover the two-flop synchroniser plus the output register
  property p_nmi;
    clock_security_fail [*3] ##0 !reset_req |=> core_req.rank == vim_pkg::RANK_NMI
      && core_req.vector == 32'h0000_0008;
  endproperty
  a_nmi: assert property (p_nmi) else $error("clock failure did not raise nmi");
  property p_severe;
    core_exc.severe |=> core_req.valid && $signed(core_req.rank) <= vim_pkg::RANK_SEVERE;
  endproperty
  a_severe: assert property (p_severe) else $error("severe fault outranked");
  property p_vec;
    core_req.valid && core_req.number >= 7'h10 |->
      core_req.vector == 32'h0000_0040 + 32'({core_req.number - 7'h10, 2'b00});
  endproperty
  a_vec: assert property (p_vec) else $error("channel vector wrong");
  property p_rank;
    core_req.valid && core_req.number >= 7'h10 |-> core_req.rank[5:4] == 2'b00;
  endproperty
  a_rank: assert property (p_rank) else $error("channel rank outside four bits");
  property p_pset;
    pend_set |=> pend_state;
  endproperty
  a_pset: assert property (p_pset) else $error("pendable request not set");
  property p_pclr;
    (pend_clear || exc_taken && core_req.number == vim_pkg::EXC_PEND) && !pend_set
      |=> !pend_state;
  endproperty
  a_pclr: assert property (p_pclr) else $error("pendable request not cleared");
endmodule // vim_checker

// ### dv/vim_core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Core model
// ---------------------------------------------------------------------------
module vim_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire vim_pkg::vim_req_t core_req,
  output logic exc_taken
);
  logic [3:0] entry_cnt;
  logic [6:0] entry_num;
  // Entry restarts when the request is withdrawn or replaced by a late one
  // Zero latency stalls entry so a request can be watched while it stands
  always_ff @(posedge core_clk) begin
    entry_num <= core_req.number;
    if (rst || !core_req.valid || lat == 4'h0 || core_req.number != entry_num) begin
      entry_cnt <= 4'h0;
      exc_taken <= 1'b0;
    end else begin
      entry_cnt <= (entry_cnt + 4'h1 >= lat) ? 4'h0 : entry_cnt + 4'h1;
      exc_taken <= (entry_cnt + 4'h1 >= lat);
    end
  end
endmodule // vim_core_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [67:0] chan_req = '0;
  logic [67:0] chan_enable = '0;
  logic prio_we = 1'b0;
  logic [6:0] prio_sel = '0;
  logic [3:0] prio_wdata = '0;
  logic clock_security_fail = 1'b0;
  logic supply_voltage_detector = 1'b0;
  logic [6:0] first_dma_channel_irq = '0;
  logic [1:0] converter_irq = '0;
  vim_pkg::vim_core_exc_t core_exc = '0;
  logic pend_set = 1'b0;
  logic pend_clear = 1'b0;
  logic reset_req = 1'b0;
  logic exc_taken;
  logic [3:0] lat = '0;
  vim_pkg::vim_req_t core_req;
  logic pend_state;
  logic [23:0] tick_calib;
  int fails = 0;
  int n_compared = 0;
  always #2 core_clk = ~core_clk;
  vim_top dut (.core_clk, .rst, .chan_req, .chan_enable, .prio_we, .prio_sel, .prio_wdata,
    .clock_security_fail, .supply_voltage_detector, .first_dma_channel_irq, .converter_irq,
    .core_exc, .pend_set, .pend_clear, .reset_req, .exc_taken, .core_req, .pend_state,
    .tick_calib);
  vim_core_model core (.core_clk, .rst, .lat, .core_req, .exc_taken);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Synchronised pins take three edges to reach core_req, one more gives margin
  task automatic settle;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic expect_req(logic [6:0] num, logic [5:0] rank, logic [31:0] vec);
    settle();
    chk("valid", {31'h0, core_req.valid}, 32'h1);
    chk("number", {25'h0, core_req.number}, {25'h0, num});
    chk("rank", {26'h0, core_req.rank}, {26'h0, rank});
    chk("vector", core_req.vector, vec);
  endtask
  task automatic prio(logic [6:0] sel, logic [3:0] val);
    prio_sel = sel;
    prio_wdata = val;
    prio_we = 1'b1;
    @(negedge core_clk);
    prio_we = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_channels;
    chk("calib", {8'h0, tick_calib}, 32'h0000_2328);
    chk("reset valid", {31'h0, core_req.valid}, 32'h0);
    chk("reset rank", {26'h0, core_req.rank}, 32'h10);
    chk("reset pend", {31'h0, pend_state}, 32'h0);
    chan_enable = '1;
    chan_req[5] = 1'b1;
    expect_req(7'h15, 6'h0c, 32'h0000_0054);
    chan_req[5] = 1'b0;
    supply_voltage_detector = 1'b1;
    expect_req(7'h11, 6'h08, 32'h0000_0044);
    supply_voltage_detector = 1'b0;
    for (int i = 0; i < 7; i++) begin
      first_dma_channel_irq = 7'(1 << i);
      expect_req(7'(27 + i), 6'h0f, 32'(32'h6c + 4 * i));
    end
    first_dma_channel_irq = '0;
    for (int i = 0; i < 2; i++) begin
      converter_irq = 2'(1 << i);
      expect_req(7'h22, 6'h0f, 32'h0000_0088);
    end
    converter_irq = '0;
    chan_enable = '0;
    chan_req[3] = 1'b1;
    settle();
    chk("disabled", {31'h0, core_req.valid}, 32'h0);
    chan_req = '0;
    chan_enable = '1;
  endtask
  // Equal priorities go to the lower position, then a late fault overtakes
  task automatic t_tie_late;
    prio(7'd40, 4'h3);
    prio(7'd30, 4'h3);
    prio(7'h7f, 4'h0);
    chan_req[40] = 1'b1;
    chan_req[30] = 1'b1;
    expect_req(7'd46, 6'h03, 32'h0000_00b8);
    core_exc.access_fault = 1'b1;
    expect_req(7'h05, 6'h01, 32'h0000_0014);
    core_exc = '0;
    chan_req = '0;
  endtask
  task automatic t_core;
    logic [6:0] nums[3] = '{7'h03, 7'h0b, 7'h06};
    logic [5:0] ranks[3] = '{6'h3f, 6'h03, 6'h02};
    logic [31:0] vecs[3] = '{32'h0000_000c, 32'h0000_002c, 32'h0000_0018};
    for (int i = 0; i < 3; i++) begin
      core_exc = 4'(1 << i);
      expect_req(nums[i], ranks[i], vecs[i]);
    end
    prio(7'd70, 4'h0);
    core_exc.svc = 1'b1;
    expect_req(7'h0b, 6'h00, 32'h0000_002c);
    core_exc = '0;
    clock_security_fail = 1'b1;
    expect_req(7'h02, 6'h3e, 32'h0000_0008);
    reset_req = 1'b1;
    expect_req(7'h01, 6'h3d, 32'h0000_0004);
    reset_req = 1'b0;
    clock_security_fail = 1'b0;
  endtask
  task automatic t_pend;
    settle();
    pend_set = 1'b1;
    pend_clear = 1'b1;
    @(negedge core_clk);
    pend_set = 1'b0;
    chk("set wins", {31'h0, pend_state}, 32'h1);
    @(negedge core_clk);
    pend_clear = 1'b0;
    chk("cleared", {31'h0, pend_state}, 32'h0);
    pend_set = 1'b1;
    @(negedge core_clk);
    pend_set = 1'b0;
    expect_req(7'h0e, 6'h05, 32'h0000_0038);
    lat = 4'h2;
    settle();
    settle();
    chk("taken", {31'h0, pend_state}, 32'h0);
    chk("idle", {31'h0, core_req.valid}, 32'h0);
    lat = 4'h0;
  endtask
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_channels();
    t_tie_late();
    t_core();
    t_pend();
    end_of_test();
  end
endmodule // tb_top
bind vim_top vim_checker #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk (.core_clk, .rst,
  .clock_security_fail, .reset_req, .core_exc, .pend_set, .pend_clear, .exc_taken,
  .core_req, .pend_state, .tick_calib);
